// ### irq_indirect_pkg.sv
// Purpose: shared constants and bus carriers for the interrupt enable and
//          indirect access register bank
// Assumes: 200 MHz core clock, APB with 32-bit data
// Notes:   register indices times four give the APB byte address
`default_nettype none
package irq_indirect_pkg;

    // core clock and indirect update rate
    localparam int unsigned CORE_CLK_HZ   = 200_000_000;
    localparam int unsigned UPDATE_RATE_HZ = 16_000;
    localparam int unsigned UPDATE_CYCLES = CORE_CLK_HZ / UPDATE_RATE_HZ;
    localparam int unsigned TICK_CNT_W    = 14;

    // register indices
    localparam logic [5:0] IDX_TIMER_PEND   = 6'h12;
    localparam logic [5:0] IDX_ALARM_PEND   = 6'h13;
    localparam logic [5:0] IDX_DONE_PEND    = 6'h14;
    localparam logic [5:0] IDX_TIMER_EN     = 6'h15;
    localparam logic [5:0] IDX_ALARM_EN     = 6'h16;
    localparam logic [5:0] IDX_DONE_EN      = 6'h17;
    localparam logic [5:0] IDX_DATA_LOW     = 6'h1c;
    localparam logic [5:0] IDX_DATA_HIGH    = 6'h1d;
    localparam logic [5:0] IDX_LOCATION     = 6'h1e;
    localparam logic [5:0] IDX_BUSY         = 6'h1f;

    // field layout
    localparam int unsigned TIMER_BITS   = 6;
    localparam int unsigned ALARM_BITS   = 8;
    localparam int unsigned DONE_BIT     = 1;
    localparam int unsigned BUSY_BIT     = 0;
    localparam int unsigned FLAG_COUNT   = 15;
    localparam int unsigned FLAG_DONE    = 14;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned LOC_W        = 8;
    localparam int unsigned STORE_DEPTH  = 256;

    // reset values
    localparam logic [5:0]  TIMER_EN_RST = 6'h00;
    localparam logic [7:0]  ALARM_EN_RST = 8'h00;
    localparam logic        DONE_EN_RST  = 1'b0;
    localparam logic [15:0] DATA_RST     = 16'h0000;
    localparam logic [7:0]  LOC_RST      = 8'h00;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_TICK,
        ST_FINISH
    } xfer_state_type;

endpackage : irq_indirect_pkg
`default_nettype wire

// ### indirect_store.sv
// Purpose: storage behind the indirect access port
// Assumes: one access per cycle, write or read
// Notes:   read data come out of a register one cycle after the request
`timescale 1ns/10ps
`default_nettype none
module indirect_store
    import irq_indirect_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [LOC_W-1:0]  loc,
    input  wire logic [DATA_W-1:0] wdata,
    output var  logic [DATA_W-1:0] rdata_q
);

    logic [DATA_W-1:0] cells [STORE_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            cells[loc] <= wdata;
        end
        if (rd_en) begin
            rdata_q <= cells[loc];
        end
    end

endmodule : indirect_store
`default_nettype wire

// ### irq_indirect_regs.sv
// Purpose: interrupt enables, pending flags and indirect access port on APB
// Assumes: event inputs are one-cycle pulses synchronous to CORE_CLK
// Notes:   zero-wait APB slave; read data registered in the setup cycle
//
// Functional notes
// R1: six timer enables at bits 5:0, one enables; bits 7:6 read zero.
// R2: six power alarm enables at bits 7:2, one per output transistor.
// R3: loop closure enable bit 1, ring trip enable bit 0 of second register.
// R4: indirect done enable at bit 1; other bits read zero; resets to zero.
// R5: low data byte holds bits 7:0, read/write, resets to zero.
// R6: high data byte holds bits 15:8; both form the transfer word.
// R7: data then location write stores the word at the next update.
// R8: location write without new data loads the word from storage.
// R9: transfers serviced only on 16 kHz update ticks.
// R10: done flag set on completion; write one clears, zero keeps.
// R11: busy status bit 0 high from location write until serviced.
// R12: pending flags clear on writing one; enables match flag positions.
// R13: interrupt request while any enabled flag is set.
// R14: software waits for busy clear or done before next access.
`timescale 1ns/10ps
`default_nettype none
module irq_indirect_regs
    import irq_indirect_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = UPDATE_CYCLES
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  NRST,
    input  wire apb_req_type           APB_REQ,
    output var  apb_rsp_type           APB_RSP,
    input  wire logic [TIMER_BITS-1:0] TIMER_EVENTS,
    input  wire logic [ALARM_BITS-1:0] ALARM_EVENTS,
    output logic                       IRQ
);

    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

    logic                  setup_rd;
    logic                  wr_acc;
    logic [5:0]            idx;
    logic                  mapped;
    logic [7:0]            wbyte;
    logic [FLAG_COUNT-1:0] events;
    logic [FLAG_COUNT-1:0] clears;
    logic [FLAG_COUNT-1:0] enables;
    logic                  tick;
    logic                  done_evt;
    logic [DATA_W-1:0]     store_rdata;
    logic                  store_wr;
    logic                  store_rd;

    logic [TIMER_BITS-1:0] tmr_en_q,  tmr_en_d;
    logic [ALARM_BITS-1:0] alm_en_q,  alm_en_d;
    logic                  done_en_q, done_en_d;
    logic [DATA_W-1:0]     data_q,    data_d;
    logic [LOC_W-1:0]      loc_q,     loc_d;
    logic                  dirty_q,   dirty_d;
    logic                  op_wr_q,   op_wr_d;
    xfer_state_type        state_q,   state_d;
    logic [TICK_CNT_W-1:0] tick_q,    tick_d;
    logic [FLAG_COUNT-1:0] pend_q,    pend_d;
    logic                  irq_q,     irq_d;
    logic [31:0]           rdata_q,   rdata_d;
    logic                  err_q,     err_d;

    // bus decode
    assign idx      = APB_REQ.paddr[7:2];
    assign setup_rd = APB_REQ.psel && !APB_REQ.penable;
    assign wr_acc   = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && !err_q;
    assign wbyte    = APB_REQ.pwdata[7:0];

    always_comb begin
        mapped = (APB_REQ.paddr[1:0] == 2'b00);
        case (idx)
            IDX_TIMER_PEND, IDX_ALARM_PEND, IDX_DONE_PEND,
            IDX_TIMER_EN, IDX_ALARM_EN, IDX_DONE_EN,
            IDX_DATA_LOW, IDX_DATA_HIGH, IDX_LOCATION, IDX_BUSY: begin
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // read data and error sampled in setup, stable through access
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup_rd) begin
            err_d   = !mapped;
            rdata_d = RDATA_ZERO;
            case (idx)
                IDX_TIMER_PEND: rdata_d[TIMER_BITS-1:0] = pend_q[5:0];
                IDX_ALARM_PEND: rdata_d[ALARM_BITS-1:0] = pend_q[13:6];
                IDX_DONE_PEND:  rdata_d[DONE_BIT]       = pend_q[FLAG_DONE];
                IDX_TIMER_EN:   rdata_d[TIMER_BITS-1:0] = tmr_en_q;   // R1
                IDX_ALARM_EN:   rdata_d[ALARM_BITS-1:0] = alm_en_q;
                IDX_DONE_EN:    rdata_d[DONE_BIT]       = done_en_q;  // R4
                IDX_DATA_LOW:   rdata_d[7:0]            = data_q[7:0];
                IDX_DATA_HIGH:  rdata_d[7:0]            = data_q[15:8];
                IDX_LOCATION:   rdata_d[7:0]            = loc_q;
                IDX_BUSY:       rdata_d[BUSY_BIT]       = (state_q != ST_IDLE); // R11
                default:        rdata_d                 = RDATA_ZERO;
            endcase
        end
    end

    // one driver for the whole response carrier
    assign APB_RSP = '{prdata:  rdata_q,
                       pready:  1'b1,
                       pslverr: APB_REQ.psel && APB_REQ.penable && err_q};

    // enable registers
    always_comb begin
        tmr_en_d  = tmr_en_q;
        alm_en_d  = alm_en_q;
        done_en_d = done_en_q;
        if (wr_acc && idx == IDX_TIMER_EN) begin
            tmr_en_d = wbyte[TIMER_BITS-1:0]; // R1
        end
        if (wr_acc && idx == IDX_ALARM_EN) begin
            alm_en_d = wbyte; // R2 R3
        end
        if (wr_acc && idx == IDX_DONE_EN) begin
            done_en_d = wbyte[DONE_BIT]; // R4
        end
    end

    // update tick generator
    always_comb begin
        tick   = (tick_q == TICK_LAST);
        tick_d = tick ? '0 : tick_q + 1'b1;
    end

    // indirect transfer sequencing
    always_comb begin
        data_d   = data_q;
        loc_d    = loc_q;
        dirty_d  = dirty_q;
        op_wr_d  = op_wr_q;
        state_d  = state_q;
        store_wr = 1'b0;
        store_rd = 1'b0;
        done_evt = 1'b0;
        if (wr_acc && idx == IDX_DATA_LOW) begin
            data_d[7:0] = wbyte; // R5
            dirty_d     = 1'b1;
        end
        if (wr_acc && idx == IDX_DATA_HIGH) begin
            data_d[15:8] = wbyte; // R6
            dirty_d      = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if (wr_acc && idx == IDX_LOCATION) begin
                    loc_d   = wbyte;
                    op_wr_d = dirty_q || dirty_d; // R7 R8
                    dirty_d = 1'b0;
                    state_d = ST_WAIT_TICK; // R11
                end
            end
            ST_WAIT_TICK: begin
                if (tick) begin // R9
                    store_wr = op_wr_q; // R7
                    store_rd = !op_wr_q;
                    state_d  = ST_FINISH;
                end
            end
            ST_FINISH: begin
                if (!op_wr_q) begin
                    data_d = store_rdata; // R8
                end
                done_evt = 1'b1; // R10
                state_d  = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    indirect_store u_store (
        .clk     (CORE_CLK),
        .wr_en   (store_wr),
        .rd_en   (store_rd),
        .loc     (loc_q),
        .wdata   (data_q),
        .rdata_q (store_rdata)
    );

    // pending flags, enables lined up position by position
    assign events  = {done_evt, ALARM_EVENTS, TIMER_EVENTS};
    assign enables = {done_en_q, alm_en_q, tmr_en_q};

    always_comb begin
        clears = '0;
        if (wr_acc && idx == IDX_TIMER_PEND) begin
            clears[5:0] = wbyte[TIMER_BITS-1:0];
        end
        if (wr_acc && idx == IDX_ALARM_PEND) begin
            clears[13:6] = wbyte;
        end
        if (wr_acc && idx == IDX_DONE_PEND) begin
            clears[FLAG_DONE] = wbyte[DONE_BIT]; // R10
        end
    end

    // set wins over a clear in the same cycle
    for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
        always_comb begin
            pend_d[i] = events[i] || (pend_q[i] && !clears[i]); // R12
        end
    end

    always_comb begin
        irq_d = |(pend_q & enables); // R13
    end

    assign IRQ = irq_q;

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            tmr_en_q  <= TIMER_EN_RST;
            alm_en_q  <= ALARM_EN_RST;
            done_en_q <= DONE_EN_RST;
            data_q    <= DATA_RST;
            loc_q     <= LOC_RST;
            dirty_q   <= 1'b0;
            op_wr_q   <= 1'b0;
            state_q   <= ST_IDLE;
            tick_q    <= '0;
            pend_q    <= '0;
            irq_q     <= 1'b0;
            rdata_q   <= RDATA_ZERO;
            err_q     <= 1'b0;
        end else begin
            tmr_en_q  <= tmr_en_d;
            alm_en_q  <= alm_en_d;
            done_en_q <= done_en_d;
            data_q    <= data_d;
            loc_q     <= loc_d;
            dirty_q   <= dirty_d;
            op_wr_q   <= op_wr_d;
            state_q   <= state_d;
            tick_q    <= tick_d;
            pend_q    <= pend_d;
            irq_q     <= irq_d;
            rdata_q   <= rdata_d;
            err_q     <= err_d;
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_access_read(logic [5:0] where);
        APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && idx == where;
    endsequence

    sequence s_access_write(logic [5:0] where);
        wr_acc && idx == where;
    endsequence

    chk_timer_en_resv: assert property ( // R1
        s_access_read(IDX_TIMER_EN) |-> APB_RSP.prdata[31:6] == '0)
        else $error("timer enable reserved bits not zero");

    chk_alarm_en_store: assert property ( // R2 R3
        s_access_write(IDX_ALARM_EN) |=> alm_en_q == $past(wbyte))
        else $error("alarm enable write not stored");

    chk_alarm_en_read: assert property ( // R2 R3
        s_access_read(IDX_ALARM_EN) && !APB_RSP.pslverr
            |-> APB_RSP.prdata == {24'h00_0000, alm_en_q})
        else $error("alarm enable readback mismatch");

    chk_done_en_resv: assert property ( // R4
        s_access_read(IDX_DONE_EN) |-> APB_RSP.prdata[31:2] == '0 && !APB_RSP.prdata[0])
        else $error("done enable reserved bits not zero");

    chk_write_store: assert property ( // R7
        state_q == ST_WAIT_TICK && tick && op_wr_q
            |-> store_wr && !store_rd ##1 state_q == ST_FINISH)
        else $error("indirect write not issued on tick");

    chk_read_load: assert property ( // R8
        state_q == ST_FINISH && !op_wr_q |=> data_q == $past(store_rdata))
        else $error("indirect read did not load data word");

    chk_tick_service: assert property ( // R9
        $fell(state_q != ST_IDLE) |-> $past(tick, 2))
        else $error("transfer completed off the update tick");

    chk_done_flag_set: assert property ( // R10
        $fell(state_q != ST_IDLE) |-> pend_q[FLAG_DONE])
        else $error("done flag not set on completion");

    chk_busy_start: assert property ( // R11
        s_access_write(IDX_LOCATION) && state_q == ST_IDLE |=> (state_q == ST_WAIT_TICK))
        else $error("busy not raised by location write");

    chk_flag_clear: assert property ( // R12
        s_access_write(IDX_TIMER_PEND) && wbyte[0] && !TIMER_EVENTS[0] |=> !pend_q[0])
        else $error("write one did not clear pending flag");

    chk_irq_follow: assert property ( // R13
        ##1 IRQ == $past(|(pend_q & enables)))
        else $error("interrupt request does not follow enabled flags");

endmodule : irq_indirect_regs
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the interrupt enable and indirect access bank
// Assumes: zero-wait APB slave, update tick shortened through TICK_CYCLES
// Notes:   byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
    import irq_indirect_pkg::*;
    localparam int unsigned TICKS = 64;
    logic        clk;
    logic        nrst;
    apb_req_type req;
    apb_rsp_type rsp;
    logic [5:0]  timer_ev;
    logic [7:0]  alarm_ev;
    logic        irq;
    logic [7:0]  r;
    logic        e;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cycles = 0;

    irq_indirect_regs #(.TICK_CYCLES(TICKS)) u_dut (
        .CORE_CLK    (clk),
        .NRST        (nrst),
        .APB_REQ     (req),
        .APB_RSP     (rsp),
        .TIMER_EVENTS(timer_ev),
        .ALARM_EVENTS(alarm_ev),
        .IRQ         (irq)
    );

    always #2.5 clk = ~clk;

    task automatic summarize;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // one apb transfer: setup, access until pready sampled high, release
    task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        @(posedge clk);
        req <= '{paddr: {idx, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: wr,
                 pwdata: {24'h00_0000, wd}};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata[7:0];
        err = rsp.pslverr;
        if (!wr) `CHECK(rsp.prdata[31:8], 24'h00_0000)
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] rr;
        logic       ee;
        apb(idx, 1'b1, d, rr, ee);
        `CHECK(ee, 1'b0)
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] rr;
        logic       ee;
        apb(idx, 1'b0, 8'h00, rr, ee);
        `CHECK(rr, exp)
    endtask : rd_chk

    // poll busy status under a bound of a little over one tick period
    task automatic wait_idle;
        logic [7:0] rr;
        logic       ee;
        int         k;
        k = 0;
        do begin
            apb(IDX_BUSY, 1'b0, 8'h00, rr, ee);
            k++;
        end while (rr[0] !== 1'b0 && k < 30);
        `CHECK(rr, 8'h00)
    endtask : wait_idle

    // indirect transfer; write when data bytes are loaded first, else read
    task automatic ind(input logic [7:0] loc, input logic [15:0] d, input logic wrop);
        if (wrop) begin
            wr(IDX_DATA_LOW, d[7:0]);
            wr(IDX_DATA_HIGH, d[15:8]);
        end
        wr(IDX_LOCATION, loc);
        rd_chk(IDX_BUSY, 8'h01);
        // location write while busy must be dropped
        wr(IDX_LOCATION, ~loc);
        rd_chk(IDX_DONE_PEND, 8'h00);
        wait_idle();
        rd_chk(IDX_DONE_PEND, 8'h02);
        `CHECK(irq, 1'b1)
        rd_chk(IDX_DATA_LOW, d[7:0]);
        rd_chk(IDX_DATA_HIGH, d[15:8]);
        rd_chk(IDX_LOCATION, loc);
        wr(IDX_DONE_PEND, 8'h00);
        rd_chk(IDX_DONE_PEND, 8'h02);
        wr(IDX_DONE_PEND, 8'h02);
        rd_chk(IDX_DONE_PEND, 8'h00);
        `CHECK(irq, 1'b0)
    endtask : ind

    // one event: latched while masked, raises irq once enabled, cleared by one
    task automatic irq_case(input logic alarm, input int i);
        logic [5:0] pi;
        logic [5:0] ei;
        pi = alarm ? IDX_ALARM_PEND : IDX_TIMER_PEND;
        ei = alarm ? IDX_ALARM_EN : IDX_TIMER_EN;
        wr(ei, 8'h00);
        @(posedge clk);
        if (alarm) alarm_ev <= 8'(1 << i);
        else timer_ev <= 6'(1 << i);
        @(posedge clk);
        alarm_ev <= 8'h00;
        timer_ev <= 6'h00;
        repeat (2) @(posedge clk);
        #1 `CHECK(irq, 1'b0)
        rd_chk(pi, 8'(1 << i));
        wr(ei, 8'(1 << i));
        repeat (2) @(posedge clk);
        #1 `CHECK(irq, 1'b1)
        wr(pi, 8'h00);
        rd_chk(pi, 8'(1 << i));
        wr(pi, 8'(1 << i));
        rd_chk(pi, 8'h00);
        `CHECK(irq, 1'b0)
    endtask : irq_case

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        timer_ev = 6'h00;
        alarm_ev = 8'h00;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(IDX_DONE_EN, 8'h00);
        rd_chk(IDX_DATA_LOW, 8'h00);
        rd_chk(IDX_BUSY, 8'h00);
        wr(IDX_TIMER_EN, 8'hFF);
        rd_chk(IDX_TIMER_EN, 8'h3F);
        wr(IDX_ALARM_EN, 8'hFF);
        rd_chk(IDX_ALARM_EN, 8'hFF);
        wr(IDX_DONE_EN, 8'hFF);
        rd_chk(IDX_DONE_EN, 8'h02);
        apb(6'h00, 1'b1, 8'h00, r, e);
        `CHECK(e, 1'b1)
        apb(6'h18, 1'b0, 8'h00, r, e);
        `CHECK(e, 1'b1)
        `CHECK(r, 8'h00)
        rd_chk(IDX_DONE_EN, 8'h02);
        // dummy write of location zero puts later location writes away from a tick
        wr(IDX_DATA_LOW, 8'h00);
        wr(IDX_LOCATION, 8'h00);
        wait_idle();
        wr(IDX_DONE_PEND, 8'h02);
        ind(8'h01, 16'h1234, 1'b1);
        ind(8'hFF, 16'hBEEF, 1'b1);
        ind(8'h01, 16'h1234, 1'b0);
        ind(8'hFF, 16'hBEEF, 1'b0);
        wr(IDX_DONE_EN, 8'h00);
        for (int i = 0; i < 6; i++) irq_case(1'b0, i);
        for (int i = 0; i < 8; i++) irq_case(1'b1, i);
        summarize();
    end
endmodule : tb
`default_nettype wire
